// [hdl/i2sr_params.svh]
// register offsets, field positions and reset values for the status and abort block
`ifndef I2SR_PARAMS_SVH
`define I2SR_PARAMS_SVH
`define I2SR_OFS_STATUS 32'h5000_1370
`define I2SR_OFS_TXLVL 32'h5000_1374
`define I2SR_OFS_RXLVL 32'h5000_1378
`define I2SR_OFS_HOLD 32'h5000_137C
`define I2SR_OFS_ABORT 32'h5000_1380
`define I2SR_OFS_CTRL 32'h5000_1384
`define I2SR_ST_SLV 6
`define I2SR_ST_MST 5
`define I2SR_ST_RXFULL 4
`define I2SR_ST_RXNE 3
`define I2SR_ST_TXEMPTY 2
`define I2SR_ST_TXSPACE 1
`define I2SR_ST_ACT 0
`define I2SR_AB_SLVRD 15
`define I2SR_AB_SLVARB 14
`define I2SR_AB_FLUSH 13
`define I2SR_AB_ARB 12
`define I2SR_AB_MDIS 11
`define I2SR_AB_10BRD 10
`define I2SR_CMD_READ 8
`define I2SR_CTL_EN 0
`define I2SR_CTL_MST 1
`define I2SR_CTL_RSTRT 5
`define I2SR_CTL_TENBIT 6
`define I2SR_HOLD_RST 16'h0001
`define I2SR_CTL_RST 16'h0022
`define I2SR_EN_DELAY 2'h2
`endif

// [hdl/i2sr_pkg.sv]
// types shared by the status and abort reporting block
package i2sr_pkg;
    typedef logic [15:0] i2sr_word_t;
    // fifo occupancy snapshot from the fifo cores
    typedef struct packed {
        logic [5:0] tx_count;
        logic [5:0] rx_count;
    } i2sr_fifo_s;
    // bus-side events from the master and slave engines
    typedef struct packed {
        logic slave_read_req;
        logic slave_tx_active;
        logic master_start_req;
        logic master_abort_arbitration_lost;
        logic master_read_10bit;
        logic scl_rise;
        logic sda_in;
        logic sda_intended;
    } i2sr_bus_ev_s;
    typedef enum logic [1:0] {
        I2SR_OFF = 2'b00,
        I2SR_GOING_ON = 2'b01,
        I2SR_ON = 2'b10,
        I2SR_GOING_OFF = 2'b11
    } i2sr_en_e;
endpackage : i2sr_pkg

// [hdl/i2sr_status_abort.sv]
// status, fifo level, sda hold and transmit abort cause registers of the i2c controller
// Functional notes
// R01: status bit 6 shows slave fsm busy
// R02: status bit 5 shows master fsm busy
// R03: status bit 4 set when rx full
// R04: status bit 3 set when rx nonempty
// R05: status bit 2 tx empty, resets one
// R06: tx empty flag never raises interrupt
// R07: status bit 1 tx has space, resets one
// R08: status bit 0 overall activity, resets zero
// R09: tx fill count in bits 5:0
// R10: rx fill count in bits 5:0
// R11: bit 15 slave read with read command
// R12: slave bus loss sets bits 14, 12
// R13: sda mismatch at scl rise means loss
// R14: stale tx data on slave read: bit 13, abort
// R15: bit 12 on master arbitration loss
// R16: master and slave run concurrently
// R17: bit 11 master start while master disabled
// R18: bit 10 tenbit read without restart
// R19: disable flushes fifos, two clock enable delay
// R20: sda hold cycles register, resets one
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/10ps
`include "i2sr_params.svh"
module i2sr_status_abort
    import i2sr_pkg::*;
#(
    parameter int FIFO_DEPTH = 32
) (
    input wire logic CLK_SYS_I,
    input wire logic RESETN_I,
    input wire logic CE_I,
    input wire logic [31:0] ADDR_I,
    input wire logic [15:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [15:0] RDATA_O,
    input wire logic SLAVE_FSM_BUSY_I,
    input wire logic MASTER_FSM_BUSY_I,
    input wire i2sr_fifo_s FIFO_I,
    input wire i2sr_bus_ev_s BUS_EV_I,
    input wire logic CMD_WR_I,
    input wire logic [15:0] CMD_DATA_I,
    input wire logic ABORT_CLR_I,
    output logic TRANSMIT_ABORT_IRQ_O,
    output logic FIFO_FLUSH_O,
    output logic CTRL_ENABLED_O,
    output logic MASTER_MODE_O,
    output logic RESTART_ALLOW_O,
    output logic TENBIT_MODE_O,
    output logic [15:0] DATA_HOLD_CYCLES_O
);

    localparam logic [5:0] FULL_COUNT = 6'(FIFO_DEPTH);

    i2sr_word_t ctrl_q;
    i2sr_word_t hold_q;
    i2sr_word_t abort_q;
    i2sr_word_t abort_set;
    i2sr_word_t status_w;
    i2sr_word_t rdata_d;
    i2sr_en_e en_state_q;
    logic [1:0] en_cnt_q;
    logic slv_busy_q;
    logic mst_busy_q;
    logic rx_full_q;
    logic rx_ne_q;
    logic tx_empty_q;
    logic tx_space_q;
    logic act_q;
    logic [5:0] txfl_q;
    logic [5:0] rxfl_q;
    logic bus_lost;
    logic irq_q;
    logic flush_q;

    // address compare used by both the write and read decoders
    function automatic logic hit(input logic [31:0] a, input logic [31:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    // software-written control and hold registers
    always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            ctrl_q <= `I2SR_CTL_RST;
            hold_q <= `I2SR_HOLD_RST;
        end else if (CE_I && WR_I) begin
            if (hit(ADDR_I, `I2SR_OFS_HOLD)) begin
                hold_q <= WDATA_I; // R20
            end else if (hit(ADDR_I, `I2SR_OFS_CTRL)) begin
                ctrl_q <= WDATA_I;
            end
        end
    end

    // enable sequencing: the enable bit takes two clocks to land
    always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            en_state_q <= I2SR_OFF;
            en_cnt_q <= 2'h0;
        end else if (CE_I) begin
            case (en_state_q)
                I2SR_OFF: begin
                    if (ctrl_q[`I2SR_CTL_EN]) begin
                        en_state_q <= I2SR_GOING_ON;
                        en_cnt_q <= 2'h1;
                    end
                end
                I2SR_GOING_ON: begin
                    en_cnt_q <= en_cnt_q + 2'h1;
                    if (en_cnt_q == `I2SR_EN_DELAY - 2'h1) begin
                        en_state_q <= I2SR_ON; // R19
                    end
                end
                I2SR_ON: begin
                    if (!ctrl_q[`I2SR_CTL_EN]) begin
                        en_state_q <= I2SR_GOING_OFF;
                        en_cnt_q <= 2'h1;
                    end
                end
                default: begin
                    en_cnt_q <= en_cnt_q + 2'h1;
                    if (en_cnt_q == `I2SR_EN_DELAY - 2'h1) begin
                        en_state_q <= I2SR_OFF; // R19
                    end
                end
            endcase
        end
    end

    // fifo flush held while the controller is off
    always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            flush_q <= 1'b1;
        end else if (CE_I) begin
            flush_q <= (en_state_q == I2SR_OFF) || (en_state_q == I2SR_GOING_OFF); // R19
        end
    end

    // registered status flags; fifo flags follow the occupancy counts
    always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            slv_busy_q <= 1'b0;
            mst_busy_q <= 1'b0;
            rx_full_q <= 1'b0;
            rx_ne_q <= 1'b0;
            tx_empty_q <= 1'b1;
            tx_space_q <= 1'b1;
            act_q <= 1'b0;
            txfl_q <= 6'h00;
            rxfl_q <= 6'h00;
        end else if (CE_I) begin
            slv_busy_q <= SLAVE_FSM_BUSY_I; // R01
            mst_busy_q <= MASTER_FSM_BUSY_I; // R02 R16
            rx_full_q <= (FIFO_I.rx_count == FULL_COUNT); // R03
            rx_ne_q <= (FIFO_I.rx_count != 6'h00); // R04
            tx_empty_q <= (FIFO_I.tx_count == 6'h00); // R05
            tx_space_q <= (FIFO_I.tx_count != FULL_COUNT); // R07
            act_q <= SLAVE_FSM_BUSY_I | MASTER_FSM_BUSY_I; // R08
            txfl_q <= FIFO_I.tx_count; // R09
            rxfl_q <= FIFO_I.rx_count; // R10
        end
    end

    // sda compared with the driven bit on each scl rise while the slave sends
    assign bus_lost = BUS_EV_I.slave_tx_active && BUS_EV_I.scl_rise &&
                      (BUS_EV_I.sda_in != BUS_EV_I.sda_intended); // R13

    // abort cause set terms
    always_comb begin
        abort_set = 16'h0000;
        if (BUS_EV_I.slave_read_req && CMD_WR_I && CMD_DATA_I[`I2SR_CMD_READ]) begin
            abort_set[`I2SR_AB_SLVRD] = 1'b1; // R11
        end
        if (bus_lost) begin
            abort_set[`I2SR_AB_SLVARB] = 1'b1; // R12
            abort_set[`I2SR_AB_ARB] = 1'b1; // R12
        end
        if (BUS_EV_I.slave_read_req && (FIFO_I.tx_count != 6'h00)) begin
            abort_set[`I2SR_AB_FLUSH] = 1'b1; // R14
        end
        if (BUS_EV_I.master_abort_arbitration_lost) begin
            abort_set[`I2SR_AB_ARB] = 1'b1; // R15 R16
        end
        if (BUS_EV_I.master_start_req && !ctrl_q[`I2SR_CTL_MST]) begin
            abort_set[`I2SR_AB_MDIS] = 1'b1; // R17
        end
        if (BUS_EV_I.master_read_10bit && !ctrl_q[`I2SR_CTL_RSTRT]) begin
            abort_set[`I2SR_AB_10BRD] = 1'b1; // R18
        end
    end

    // sticky abort cause; a new cause in the clearing cycle survives
    always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            abort_q <= 16'h0000;
        end else if (CE_I) begin
            abort_q <= (ABORT_CLR_I ? 16'h0000 : abort_q) | abort_set;
        end
    end

    // abort request follows the cause register; tx empty never feeds it
    always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            irq_q <= 1'b0;
        end else if (CE_I) begin
            irq_q <= ((ABORT_CLR_I ? 16'h0000 : abort_q) | abort_set) != 16'h0000; // R06 R14
        end
    end

    // status word assembly, reserved bits zero
    always_comb begin
        status_w = 16'h0000;
        status_w[`I2SR_ST_SLV] = slv_busy_q;
        status_w[`I2SR_ST_MST] = mst_busy_q;
        status_w[`I2SR_ST_RXFULL] = rx_full_q;
        status_w[`I2SR_ST_RXNE] = rx_ne_q;
        status_w[`I2SR_ST_TXEMPTY] = tx_empty_q;
        status_w[`I2SR_ST_TXSPACE] = tx_space_q;
        status_w[`I2SR_ST_ACT] = act_q;
    end

    // read decode; unmapped addresses return zero
    always_comb begin
        if (hit(ADDR_I, `I2SR_OFS_STATUS)) begin
            rdata_d = status_w;
        end else if (hit(ADDR_I, `I2SR_OFS_TXLVL)) begin
            rdata_d = {10'h000, txfl_q};
        end else if (hit(ADDR_I, `I2SR_OFS_RXLVL)) begin
            rdata_d = {10'h000, rxfl_q};
        end else if (hit(ADDR_I, `I2SR_OFS_HOLD)) begin
            rdata_d = hold_q;
        end else if (hit(ADDR_I, `I2SR_OFS_ABORT)) begin
            rdata_d = abort_q;
        end else if (hit(ADDR_I, `I2SR_OFS_CTRL)) begin
            rdata_d = ctrl_q;
        end else begin
            rdata_d = 16'h0000;
        end
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            RDATA_O <= 16'h0000;
        end else if (CE_I) begin
            RDATA_O <= RD_I ? rdata_d : 16'h0000;
        end
    end

    // registered control outputs
    always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            CTRL_ENABLED_O <= 1'b0;
            MASTER_MODE_O <= 1'b0;
            RESTART_ALLOW_O <= 1'b0;
            TENBIT_MODE_O <= 1'b0;
            DATA_HOLD_CYCLES_O <= `I2SR_HOLD_RST;
        end else if (CE_I) begin
            CTRL_ENABLED_O <= (en_state_q == I2SR_ON);
            MASTER_MODE_O <= ctrl_q[`I2SR_CTL_MST];
            RESTART_ALLOW_O <= ctrl_q[`I2SR_CTL_RSTRT];
            TENBIT_MODE_O <= ctrl_q[`I2SR_CTL_TENBIT];
            DATA_HOLD_CYCLES_O <= hold_q; // R20
        end
    end

    assign TRANSMIT_ABORT_IRQ_O = irq_q;
    assign FIFO_FLUSH_O = flush_q;

endmodule : i2sr_status_abort

// [testbench/i2sr_status_abort_chk.sv]
// port assertions for the status and abort block
`timescale 1ns/10ps
`include "i2sr_params.svh"
module i2sr_status_abort_chk
    import i2sr_pkg::*;
(
    input wire logic CLK_SYS_I,
    input wire logic RESETN_I,
    input wire logic CE_I,
    input wire logic [31:0] ADDR_I,
    input wire logic [15:0] WDATA_I,
    input wire logic WR_I,
    input wire i2sr_fifo_s FIFO_I,
    input wire i2sr_bus_ev_s BUS_EV_I,
    input wire logic CMD_WR_I,
    input wire logic [15:0] CMD_DATA_I,
    input wire logic TRANSMIT_ABORT_IRQ_O,
    input wire logic FIFO_FLUSH_O,
    input wire logic CTRL_ENABLED_O,
    input wire logic MASTER_MODE_O,
    input wire logic RESTART_ALLOW_O,
    input wire logic TENBIT_MODE_O
);
    logic any_ev;
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (!RESETN_I);
    // only bus events may raise the irq, so a fifo flag never does
    assign any_ev = BUS_EV_I.slave_read_req | BUS_EV_I.scl_rise | BUS_EV_I.master_start_req
        | BUS_EV_I.master_abort_arbitration_lost | BUS_EV_I.master_read_10bit;
    a_irq_has_cause:
        assert property ($rose(TRANSMIT_ABORT_IRQ_O) |-> $past(any_ev)) else $error("irq no cause");
    a_slave_read_irq:
        assert property (CE_I && BUS_EV_I.slave_read_req && CMD_WR_I && CMD_DATA_I[8]
            |=> TRANSMIT_ABORT_IRQ_O) else $error("read conflict no irq");
    a_slave_loss_irq:
        assert property (CE_I && BUS_EV_I.slave_tx_active && BUS_EV_I.scl_rise
            && (BUS_EV_I.sda_in != BUS_EV_I.sda_intended) |=> TRANSMIT_ABORT_IRQ_O)
            else $error("bus loss no irq");
    a_stale_flush_irq:
        assert property (CE_I && BUS_EV_I.slave_read_req && FIFO_I.tx_count != 6'h00
            |=> TRANSMIT_ABORT_IRQ_O) else $error("stale flush no irq");
    a_abort_arbitration_lost_irq:
        assert property (CE_I && BUS_EV_I.master_abort_arbitration_lost |=> TRANSMIT_ABORT_IRQ_O)
            else $error("arb loss no irq");
    a_master_off_irq:
        assert property (CE_I && BUS_EV_I.master_start_req && !MASTER_MODE_O
            |=> TRANSMIT_ABORT_IRQ_O) else $error("master off no irq");
    a_tenbit_read_irq:
        assert property (CE_I && BUS_EV_I.master_read_10bit && TENBIT_MODE_O && !RESTART_ALLOW_O
            |=> TRANSMIT_ABORT_IRQ_O) else $error("tenbit read no irq");
    a_enable_delay:
        assert property (CE_I && WR_I && ADDR_I == `I2SR_OFS_CTRL && WDATA_I[0] && FIFO_FLUSH_O
            && !CTRL_ENABLED_O |=> !CTRL_ENABLED_O [*3] ##1 CTRL_ENABLED_O)
            else $error("enable delay wrong");
endmodule : i2sr_status_abort_chk
bind i2sr_status_abort i2sr_status_abort_chk chk_u (.*);

// [testbench/i2sr_far_side.sv]
// model of the remote bus side: engine levels, fifo counts, bus events
`timescale 1ns/10ps
module i2sr_far_side
    import i2sr_pkg::*;
(
    input wire logic clk_i,
    output logic slv_o,
    output logic mst_o,
    output i2sr_fifo_s fifo_o,
    output i2sr_bus_ev_s ev_o
);
    // idle engines and empty fifos at time zero
    initial begin
        slv_o = 1'b0;
        mst_o = 1'b0;
        fifo_o = '0;
        ev_o = '0;
    end
    // levels change just after an edge and then hold
    task automatic set_lv(input logic s, input logic m, input logic [5:0] t, input logic [5:0] r);
        @(posedge clk_i);
        slv_o <= s;
        mst_o <= m;
        fifo_o <= {t, r};
    endtask : set_lv
    // one-cycle event; a bad sda value only when the bench asks for it
    task automatic pulse(input i2sr_bus_ev_s e);
        @(posedge clk_i);
        ev_o <= e;
        @(posedge clk_i);
        ev_o <= '0;
    endtask : pulse
endmodule : i2sr_far_side

// [testbench/testbench.sv]
// self-checking bench for the status and abort block
`timescale 1ns/10ps
`include "i2sr_params.svh"
module testbench
    import i2sr_pkg::*;
;
    // event, control and mask per abort case; the last two must not abort
    localparam logic [7:0] EVS [8] = '{8'h80, 8'h46, 8'h80, 8'h10, 8'h20, 8'h08, 8'h20, 8'h47};
    localparam logic [15:0] CTL [8] = '{16'h0023, 16'h0023, 16'h0023, 16'h0023,
        16'h0021, 16'h0043, 16'h0023, 16'h0023};
    localparam logic [15:0] MSK [8] = '{16'h8000, 16'h5000, 16'h2000, 16'h1000,
        16'h0800, 16'h0400, 16'h0000, 16'h0000};
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic cmd_wr = 1'b0;
    logic clr = 1'b0;
    logic ce = 1'b1;
    logic [31:0] addr = '0;
    logic [15:0] wdata = '0;
    logic [15:0] rdata, hold;
    logic slv, mst, irq, flush, en, mmode, rsa, tenb, s, m;
    logic [5:0] tx, rx;
    i2sr_fifo_s fifo;
    i2sr_bus_ev_s ev;
    logic [31:0] seed = 32'hCC73A61D;
    int n_mismatch = 0;
    int check_count = 0;
    i2sr_status_abort #(.FIFO_DEPTH(32)) dut_u (.CLK_SYS_I(clk), .RESETN_I(rst_n), .CE_I(ce),
        .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
        .SLAVE_FSM_BUSY_I(slv), .MASTER_FSM_BUSY_I(mst), .FIFO_I(fifo), .BUS_EV_I(ev),
        .CMD_WR_I(cmd_wr), .CMD_DATA_I(16'h0100), .ABORT_CLR_I(clr),
        .TRANSMIT_ABORT_IRQ_O(irq), .FIFO_FLUSH_O(flush), .CTRL_ENABLED_O(en),
        .MASTER_MODE_O(mmode), .RESTART_ALLOW_O(rsa), .TENBIT_MODE_O(tenb),
        .DATA_HOLD_CYCLES_O(hold));
    i2sr_far_side far_u (.clk_i(clk), .slv_o(slv), .mst_o(mst), .fifo_o(fifo), .ev_o(ev));
    // 250 MHz system clock
    initial forever #2 clk = ~clk;
    function automatic logic [31:0] nxt(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : nxt
    // status word from engine levels and fifo counts, full at a depth of 32
    function automatic logic [15:0] st(input logic a, input logic b, input logic [5:0] t,
        input logic [5:0] r);
        return {9'h0, a, b, r == 6'd32, r != 6'd0, t == 6'd0, t != 6'd32, a | b};
    endfunction : st
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic wreg(input logic [31:0] a, input logic [15:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wreg
    // read data stand only in the cycle after the strobe
    task automatic rc(input string nm, input logic [31:0] a, input logic [15:0] e);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(nm, rdata, e);
    endtask : rc
    task automatic aclr();
        @(posedge clk);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
    endtask : aclr
    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : close_out
    // watchdog: the tests need well under 2000 cycles
    initial begin
        repeat (6000) @(posedge clk);
        n_mismatch++;
        close_out();
    end
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        rc("status", `I2SR_OFS_STATUS, 16'h0006);
        rc("txlvl", `I2SR_OFS_TXLVL, 16'h0000);
        rc("rxlvl", `I2SR_OFS_RXLVL, 16'h0000);
        rc("hold", `I2SR_OFS_HOLD, `I2SR_HOLD_RST);
        rc("abort", `I2SR_OFS_ABORT, 16'h0000);
        chk("modes", {13'h0, tenb, rsa, mmode}, 16'h0003);
        wreg(`I2SR_OFS_TXLVL, 16'hFFFF);
        rc("ro", `I2SR_OFS_TXLVL, 16'h0000);
        rc("unmapped", 32'h5000_1390, 16'h0000);
        $display("reset test done");
        // random levels with full, empty and one-off corners first
        for (int i = 0; i < 24; i++) begin
            seed = nxt(seed);
            {s, m} = seed[1:0];
            tx = 6'(seed[15:8] % 33);
            rx = 6'(seed[23:16] % 33);
            if (i == 0) {tx, rx} = {6'h20, 6'h20};
            if (i == 1) {tx, rx} = 12'h000;
            if (i == 2) {tx, rx} = {6'h1F, 6'h01};
            far_u.set_lv(s, m, tx, rx);
            repeat (3) @(posedge clk);
            rc("status", `I2SR_OFS_STATUS, st(s, m, tx, rx));
            rc("txlvl", `I2SR_OFS_TXLVL, {10'h0, tx});
            rc("rxlvl", `I2SR_OFS_RXLVL, {10'h0, rx});
        end
        $display("level test done");
        seed = nxt(seed);
        wreg(`I2SR_OFS_HOLD, seed[15:0]);
        rc("hold", `I2SR_OFS_HOLD, seed[15:0]);
        chk("hold_out", hold, seed[15:0]);
        // disabled controller flushes; enable shows three edges after the write lands
        wreg(`I2SR_OFS_CTRL, 16'h0022);
        repeat (4) @(posedge clk);
        chk("flush", {15'h0, flush}, 16'h0001);
        wreg(`I2SR_OFS_CTRL, 16'h0023);
        repeat (2) @(posedge clk);
        #1 chk("en4", {15'h0, en}, 16'h0000);
        @(posedge clk);
        #1 chk("en5", {15'h0, en}, 16'h0001);
        $display("enable test done");
        for (int k = 0; k < 8; k++) begin
            wreg(`I2SR_OFS_CTRL, CTL[k]);
            far_u.set_lv(1'b0, 1'b0, (k == 2) ? 6'h05 : 6'h00, 6'h00);
            aclr();
            fork
                far_u.pulse(EVS[k]);
                begin
                    @(posedge clk);
                    cmd_wr <= (k == 0);
                    @(posedge clk);
                    cmd_wr <= 1'b0;
                end
            join
            @(posedge clk);
            #1 chk("irq", {15'h0, irq}, {15'h0, MSK[k] != 16'h0});
            rc("abort", `I2SR_OFS_ABORT, MSK[k]);
        end
        aclr();
        rc("cleared", `I2SR_OFS_ABORT, 16'h0000);
        $display("abort test done");
        // a write while the clock enable is low must not land
        @(posedge clk);
        ce <= 1'b0;
        wreg(`I2SR_OFS_HOLD, ~seed[15:0]);
        @(posedge clk);
        ce <= 1'b1;
        rc("frozen", `I2SR_OFS_HOLD, seed[15:0]);
        $display("enable freeze test done");
        close_out();
    end
endmodule : testbench
